// ### rtl/hpsl_pkg.sv
// Constants and carrier types for the host pin, strap and LED block
package hpsl_pkg;
    // Register byte offsets
    localparam logic [7:0] HPSL_OFS_CFLAG = 8'h00;
    localparam logic [7:0] HPSL_OFS_CMASK = 8'h04;
    localparam logic [7:0] HPSL_OFS_SFLAG = 8'h08;
    localparam logic [7:0] HPSL_OFS_SMASK = 8'h0C;
    localparam logic [7:0] HPSL_OFS_STAT = 8'h10;
    // Common event flag bit positions
    localparam int HPSL_EV_CONN = 0;
    localparam int HPSL_EV_DISC = 1;
    localparam int HPSL_EV_RECV = 2;
    localparam int HPSL_EV_TOUT = 3;
    localparam int HPSL_EV_WOL = 4;
    localparam int HPSL_NEV = 5;
    localparam int HPSL_NSOCK = 8;
    // Status register bit positions
    localparam int HPSL_ST_ANEG = 0;
    localparam int HPSL_ST_FDX = 1;
    localparam int HPSL_ST_S100 = 2;
    localparam int HPSL_ST_MODE = 3;
    localparam int HPSL_ST_HIF = 6;
    localparam int HPSL_ST_TEST = 7;
    localparam int HPSL_ST_PDN = 8;
    localparam int HPSL_ST_RDY = 9;
    localparam int HPSL_ST_LINK = 10;
    // Reset values
    localparam logic [HPSL_NEV-1:0] HPSL_CMASK_RST = 5'h00;
    localparam logic [HPSL_NSOCK-1:0] HPSL_SMASK_RST = 8'h00;
    localparam logic [2:0] HPSL_MODE_NORMAL = 3'h7;
    // Timing
    localparam int HPSL_CLK_MHZ = 250;
    localparam int HPSL_SETTLE_MS = 150;
    localparam int HPSL_SETTLE_CYC = HPSL_SETTLE_MS * HPSL_CLK_MHZ * 1000;
    localparam int HPSL_XTAL_MHZ = 25;
    localparam int HPSL_BLINK_MS = 40;
    localparam int HPSL_BLINK_XTAL = HPSL_BLINK_MS * HPSL_XTAL_MHZ * 1000;

    // Strap values caught at reset release
    typedef struct packed {
        logic host_if;
        logic [2:0] mode;
        logic spd100;
        logic full_dup;
        logic autoneg;
    } hpsl_strap_t;

    // Negotiated link state from the PHY logic
    typedef struct packed {
        logic up;
        logic full_dup;
        logic spd100;
        logic activity;
    } hpsl_link_t;
endpackage

// ### rtl/hpsl_top.sv
// Host pins, straps, interrupt and LED logic with an APB register slave
// Overview of operation
// [R1] Low hardware reset pin reinitialises the device
// [R2] Host holds reset low at least 2us
// [R3] Host waits 150ms after release before access
// [R4] Serial access only while slave select low
// [R5] Interrupt pin low on socket and wake events
// [R6] Writing a one to a flag clears it
// [R7] Each source has its own mask bit
// [R8] Power-down pin high enters power-down mode
// [R9] Autoneg strap high enables auto-negotiation
// [R10] Duplex strap sampled in reset, high full
// [R11] Rate strap sampled in reset, high 100M
// [R12] LED pins give mode in reset, 111 normal
// [R13] After reset LEDs show link state, active low
// [R14] Timing derived from 25MHz crystal input; only the blink uses it, the settle count runs on mclk
// [R15] Straps caught at reset release, held after
// [R16] Interrupt low while any unmasked flag set
// [R17] LED pins drive only after reset release
`timescale 1ns/100ps
`default_nettype none
module hpsl_top
    import hpsl_pkg::*;
#(
    parameter int SETTLE_CYCLES = HPSL_SETTLE_CYC,
    parameter int BLINK_EDGES = HPSL_BLINK_XTAL
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Host pins
    input wire logic hw_reset_bar,
    input wire logic slave_select_bar,
    input wire logic power_down_pin,
    output logic irq_out_bar,
    // Strap pins
    input wire logic autoneg_strap,
    input wire logic link_mode_strap,
    input wire logic rate_strap,
    input wire logic host_if_enable_strap,
    // LED and mode pins
    input wire logic duplex_led_strap_hi_i,
    output logic duplex_led_strap_hi_o,
    output logic duplex_led_strap_hi_oe,
    input wire logic rate_led_strap_mid_i,
    output logic rate_led_strap_mid_o,
    output logic rate_led_strap_mid_oe,
    input wire logic link_led_strap_lo_i,
    output logic link_led_strap_lo_o,
    output logic link_led_strap_lo_oe,
    // Crystal
    input wire logic crystal_in,
    output logic crystal_out,
    // Internal events and link state
    input wire logic [HPSL_NEV-1:0] evt_pulse,
    input wire logic [HPSL_NSOCK-1:0] sock_evt_pulse,
    input wire hpsl_link_t link_state,
    // Internal controls
    output hpsl_strap_t strap_cfg,
    output logic test_mode,
    output logic power_down,
    output logic spi_accept,
    output logic dev_reset
);

    // Two-stage synchronisers for all pins
    localparam int NPIN = 11;
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] sync1_r;
    logic [NPIN-1:0] sync2_r;
    logic [NPIN-1:0] sync1_nxt;
    logic [NPIN-1:0] sync2_nxt;
    assign pin_raw = {slave_select_bar, crystal_in, link_led_strap_lo_i,
                      rate_led_strap_mid_i, duplex_led_strap_hi_i,
                      host_if_enable_strap, rate_strap, link_mode_strap,
                      autoneg_strap, power_down_pin, hw_reset_bar};

    always_comb begin
        sync1_nxt = pin_raw;
        sync2_nxt = sync1_r;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            sync1_r <= {NPIN{1'b1}};
            sync2_r <= {NPIN{1'b1}};
        end else begin
            sync1_r <= sync1_nxt;
            sync2_r <= sync2_nxt;
        end
    end

    logic hw_reset_bar_s;
    logic pdn_s;
    logic xtal_s;
    logic [2:0] mode_s;
    assign hw_reset_bar_s = sync2_r[0];
    assign pdn_s = sync2_r[1];
    assign mode_s = {sync2_r[6], sync2_r[7], sync2_r[8]};
    assign xtal_s = sync2_r[9];

    // Device reset tracking, strap capture and settle count
    logic in_rst_r;
    logic in_rst_nxt;
    hpsl_strap_t strap_r;
    hpsl_strap_t strap_nxt;
    logic [31:0] settle_r;
    logic [31:0] settle_nxt;
    logic ready_r;
    logic ready_nxt;

    always_comb begin
        in_rst_nxt = ~hw_reset_bar_s; // [R1]
        strap_nxt = strap_r;
        settle_nxt = settle_r;
        ready_nxt = ready_r;
        if (in_rst_r && hw_reset_bar_s) begin
            // Release edge: catch straps and mode pins
            strap_nxt.autoneg = sync2_r[2]; // [R9] [R15]
            strap_nxt.full_dup = sync2_r[3]; // [R10] [R15]
            strap_nxt.spd100 = sync2_r[4]; // [R11] [R15]
            strap_nxt.host_if = sync2_r[5];
            strap_nxt.mode = mode_s; // [R12] [R15]
        end
        if (in_rst_r) begin
            settle_nxt = 32'h0000_0000;
            ready_nxt = 1'b0;
        end else if (!ready_r) begin
            if (settle_r >= 32'(SETTLE_CYCLES - 1)) begin
                ready_nxt = 1'b1;
            end else begin
                settle_nxt = settle_r + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            in_rst_r <= 1'b1;
            strap_r <= '0;
            settle_r <= 32'h0000_0000;
            ready_r <= 1'b0;
        end else begin
            in_rst_r <= in_rst_nxt;
            strap_r <= strap_nxt;
            settle_r <= settle_nxt;
            ready_r <= ready_nxt;
        end
    end

    logic dev_rst;
    assign dev_rst = rst | in_rst_r;

    // Crystal edge count gives the blink tick
    logic xtal_d_r;
    logic [31:0] xcnt_r;
    logic [31:0] xcnt_nxt;
    logic blink_r;
    logic blink_nxt;
    always_comb begin
        xcnt_nxt = xcnt_r;
        blink_nxt = blink_r;
        if (xtal_s && !xtal_d_r) begin // [R14]
            if (xcnt_r >= 32'(BLINK_EDGES - 1)) begin
                xcnt_nxt = 32'h0000_0000;
                blink_nxt = ~blink_r;
            end else begin
                xcnt_nxt = xcnt_r + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (dev_rst) begin
            xtal_d_r <= 1'b0;
            xcnt_r <= 32'h0000_0000;
            blink_r <= 1'b0;
        end else begin
            xtal_d_r <= xtal_s;
            xcnt_r <= xcnt_nxt;
            blink_r <= blink_nxt;
        end
    end

    // Event flags, masks and APB slave
    logic [HPSL_NEV-1:0] cflag_r;
    logic [HPSL_NEV-1:0] cflag_nxt;
    logic [HPSL_NEV-1:0] cmask_r;
    logic [HPSL_NEV-1:0] cmask_nxt;
    logic [HPSL_NSOCK-1:0] sflag_r;
    logic [HPSL_NSOCK-1:0] sflag_nxt;
    logic [HPSL_NSOCK-1:0] smask_r;
    logic [HPSL_NSOCK-1:0] smask_nxt;
    logic [31:0] rdata_nxt;
    logic rdy_nxt;
    logic err_nxt;
    logic wr_ok;
    logic [31:0] stat_w;

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == HPSL_OFS_CFLAG) || (a == HPSL_OFS_CMASK) ||
                 (a == HPSL_OFS_SFLAG) || (a == HPSL_OFS_SMASK) ||
                 (a == HPSL_OFS_STAT);
    endfunction

    always_comb begin
        stat_w = 32'h0000_0000;
        stat_w[HPSL_ST_ANEG] = strap_r.autoneg;
        stat_w[HPSL_ST_FDX] = strap_r.full_dup;
        stat_w[HPSL_ST_S100] = strap_r.spd100;
        stat_w[HPSL_ST_MODE +: 3] = strap_r.mode;
        stat_w[HPSL_ST_HIF] = strap_r.host_if;
        stat_w[HPSL_ST_TEST] = (strap_r.mode != HPSL_MODE_NORMAL);
        stat_w[HPSL_ST_PDN] = pdn_s;
        stat_w[HPSL_ST_RDY] = ready_r;
        stat_w[HPSL_ST_LINK] = link_state.up;
    end

    always_comb begin
        wr_ok = psel && penable && pready && pwrite && !pslverr;
        cflag_nxt = cflag_r;
        cmask_nxt = cmask_r;
        sflag_nxt = sflag_r;
        smask_nxt = smask_r;
        // Write one to clear; a new event in the same cycle wins
        if (wr_ok && paddr == HPSL_OFS_CFLAG) begin
            cflag_nxt = cflag_r & ~pwdata[HPSL_NEV-1:0]; // [R6]
        end else if (wr_ok && paddr == HPSL_OFS_CMASK) begin
            cmask_nxt = pwdata[HPSL_NEV-1:0]; // [R7]
        end else if (wr_ok && paddr == HPSL_OFS_SFLAG) begin
            sflag_nxt = sflag_r & ~pwdata[HPSL_NSOCK-1:0]; // [R6]
        end else if (wr_ok && paddr == HPSL_OFS_SMASK) begin
            smask_nxt = pwdata[HPSL_NSOCK-1:0]; // [R7]
        end
        cflag_nxt = cflag_nxt | evt_pulse; // [R5]
        sflag_nxt = sflag_nxt | sock_evt_pulse; // [R5]
        // One wait state: ready and data registered for the second access cycle
        rdy_nxt = psel && penable && !pready;
        err_nxt = rdy_nxt && !mapped(paddr);
        rdata_nxt = 32'h0000_0000;
        if (rdy_nxt && !pwrite) begin
            if (paddr == HPSL_OFS_CFLAG) begin
                rdata_nxt[HPSL_NEV-1:0] = cflag_r;
            end else if (paddr == HPSL_OFS_CMASK) begin
                rdata_nxt[HPSL_NEV-1:0] = cmask_r;
            end else if (paddr == HPSL_OFS_SFLAG) begin
                rdata_nxt[HPSL_NSOCK-1:0] = sflag_r;
            end else if (paddr == HPSL_OFS_SMASK) begin
                rdata_nxt[HPSL_NSOCK-1:0] = smask_r;
            end else if (paddr == HPSL_OFS_STAT) begin
                rdata_nxt = stat_w;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (dev_rst) begin
            cflag_r <= '0;
            cmask_r <= HPSL_CMASK_RST;
            sflag_r <= '0;
            smask_r <= HPSL_SMASK_RST;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            cflag_r <= cflag_nxt;
            cmask_r <= cmask_nxt;
            sflag_r <= sflag_nxt;
            smask_r <= smask_nxt;
            prdata <= rdata_nxt;
            pready <= rdy_nxt;
            pslverr <= err_nxt;
        end
    end

    // Registered pin and control outputs
    logic irq_nxt;
    logic [2:0] led_o_nxt;
    logic led_oe_nxt;
    logic acc_nxt;
    always_comb begin
        irq_nxt = ~(|(cflag_r & cmask_r) | |(sflag_r & smask_r)); // [R16]
        led_oe_nxt = ~in_rst_r; // [R17]
        led_o_nxt[2] = ~link_state.full_dup; // [R13]
        led_o_nxt[1] = ~link_state.spd100; // [R13]
        led_o_nxt[0] = ~link_state.up |
                       (link_state.activity & blink_r); // [R13]
        acc_nxt = ~sync2_r[10] & ~pdn_s & ~in_rst_r; // [R4] [R8]
    end

    always_ff @(posedge mclk) begin
        if (dev_rst) begin
            irq_out_bar <= 1'b1;
            duplex_led_strap_hi_o <= 1'b1;
            rate_led_strap_mid_o <= 1'b1;
            link_led_strap_lo_o <= 1'b1;
            duplex_led_strap_hi_oe <= 1'b0; // [R12]
            rate_led_strap_mid_oe <= 1'b0;
            link_led_strap_lo_oe <= 1'b0;
            spi_accept <= 1'b0;
            power_down <= 1'b0;
            test_mode <= 1'b0;
            strap_cfg <= '0;
            crystal_out <= 1'b0;
            dev_reset <= 1'b1;
        end else begin
            irq_out_bar <= irq_nxt; // [R5]
            duplex_led_strap_hi_o <= led_o_nxt[2];
            rate_led_strap_mid_o <= led_o_nxt[1];
            link_led_strap_lo_o <= led_o_nxt[0];
            duplex_led_strap_hi_oe <= led_oe_nxt;
            rate_led_strap_mid_oe <= led_oe_nxt;
            link_led_strap_lo_oe <= led_oe_nxt;
            spi_accept <= acc_nxt;
            power_down <= pdn_s; // [R8]
            test_mode <= (strap_r.mode != HPSL_MODE_NORMAL); // [R12]
            strap_cfg <= strap_r;
            crystal_out <= ~xtal_s;
            dev_reset <= in_rst_r; // [R1]
        end
    end

endmodule
`default_nettype wire

// ### bench/hpsl_board.sv
// Board model: strap resistors on the LED pins and the crystal
`timescale 1ns/100ps
`default_nettype none
module hpsl_board
    import hpsl_pkg::*;
(
    // Device pin drivers, {hi,mid,lo}
    input wire logic [2:0] led_o,
    input wire logic [2:0] led_oe,
    // Resistor levels, {hi,mid,lo}
    input wire logic [2:0] pull,
    // Resolved pins and crystal
    output logic [2:0] pin,
    output logic xtal
);
    // Undriven pin settles at its resistor level
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            pin[i] = led_oe[i] ? led_o[i] : pull[i];
        end
    end
    // Free running oscillator, 48 ns period in simulation
    initial begin
        xtal = 1'b0;
        forever #24 xtal = ~xtal;
    end
endmodule
`default_nettype wire

// ### bench/hpsl_top_sva.sv
// Port assertions for the pin, interrupt and LED block
`timescale 1ns/100ps
`default_nettype none
module hpsl_top_sva
    import hpsl_pkg::*;
(
    // Clock, reset and bus answer
    input wire logic mclk,
    input wire logic rst,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic pslverr,
    // Pins and controls
    input wire logic slave_select_bar,
    input wire logic irq_out_bar,
    input wire logic duplex_led_strap_hi_o,
    input wire logic duplex_led_strap_hi_oe,
    input wire logic rate_led_strap_mid_oe,
    input wire logic link_led_strap_lo_oe,
    input wire hpsl_link_t link_state,
    input wire hpsl_strap_t strap_cfg,
    input wire logic test_mode,
    input wire logic power_down,
    input wire logic spi_accept,
    input wire logic dev_reset
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // Bus answer shape
    AST_REFUSE: assert property (pslverr |-> pready)
        else $error("slave error without ready");
    AST_READY_ONE: assert property (pready |=> !pready)
        else $error("ready held too long");
    // Reset state of pins
    AST_RST_IRQ: assert property (dev_reset |-> irq_out_bar)
        else $error("interrupt low in reset");
    AST_RST_LED: assert property (dev_reset |-> !(duplex_led_strap_hi_oe
        || rate_led_strap_mid_oe || link_led_strap_lo_oe))
        else $error("LED pin driven in reset");
    // Interrupt released only by a write or reset
    AST_IRQ_CLR: assert property ($rose(irq_out_bar) |-> dev_reset
        || $past(dev_reset) || $past(pready && pwrite, 2))
        else $error("interrupt released without cause");
    // LED follows duplex state, active low
    AST_LED_DUP: assert property (duplex_led_strap_hi_oe &&
        $past(duplex_led_strap_hi_oe) |->
        duplex_led_strap_hi_o == !$past(link_state.full_dup))
        else $error("duplex LED wrong");
    // Straps and mode held outside reset
    AST_STRAP: assert property (!dev_reset && $past(!dev_reset)
        |-> $stable(strap_cfg) && test_mode ==
        (strap_cfg.mode != HPSL_MODE_NORMAL))
        else $error("strap or mode changed");
    // Serial access gating
    AST_SEL: assert property (slave_select_bar [*4] |-> !spi_accept)
        else $error("accept without select");
    AST_PDN: assert property (spi_accept |-> !power_down && !dev_reset)
        else $error("accept while down or in reset");
    // Main scenarios
    cover property ($fell(irq_out_bar));
    cover property (pslverr);
    cover property ($fell(dev_reset));
endmodule
bind hpsl_top hpsl_top_sva hpsl_top_sva_inst (.mclk(mclk), .rst(rst),
    .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
    .slave_select_bar(slave_select_bar), .irq_out_bar(irq_out_bar),
    .duplex_led_strap_hi_o(duplex_led_strap_hi_o),
    .duplex_led_strap_hi_oe(duplex_led_strap_hi_oe),
    .rate_led_strap_mid_oe(rate_led_strap_mid_oe),
    .link_led_strap_lo_oe(link_led_strap_lo_oe),
    .link_state(link_state), .strap_cfg(strap_cfg),
    .test_mode(test_mode), .power_down(power_down),
    .spi_accept(spi_accept), .dev_reset(dev_reset));
`default_nettype wire

// ### bench/hpsl_top_test.sv
// Testbench for the host pin, strap, interrupt and LED block
`timescale 1ns/100ps
`default_nettype none
module hpsl_top_test
    import hpsl_pkg::*;
;
    logic mclk, rst, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr, fa;
    logic [31:0] pwdata, prdata, rd;
    logic hrb, ssb, pdp, irq, an, lm, rs, hif, xtal, xo, tm, pd, spa, dvr;
    logic s0, s1, x0, x1;
    logic [2:0] pin, pull;
    wire logic [2:0] lo, loe;
    logic [12:0] ev;
    hpsl_link_t lnk;
    hpsl_strap_t scfg;
    int n_errors = 0;
    int tests_run = 0;
    // Device with short settle and blink counts
    hpsl_top #(.SETTLE_CYCLES(100), .BLINK_EDGES(4)) hpsl_top_inst (
        .mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .hw_reset_bar(hrb),
        .slave_select_bar(ssb), .power_down_pin(pdp), .irq_out_bar(irq),
        .autoneg_strap(an), .link_mode_strap(lm), .rate_strap(rs),
        .host_if_enable_strap(hif), .duplex_led_strap_hi_i(pin[2]),
        .duplex_led_strap_hi_o(lo[2]), .duplex_led_strap_hi_oe(loe[2]),
        .rate_led_strap_mid_i(pin[1]), .rate_led_strap_mid_o(lo[1]),
        .rate_led_strap_mid_oe(loe[1]), .link_led_strap_lo_i(pin[0]),
        .link_led_strap_lo_o(lo[0]), .link_led_strap_lo_oe(loe[0]),
        .crystal_in(xtal), .crystal_out(xo), .evt_pulse(ev[4:0]),
        .sock_evt_pulse(ev[12:5]), .link_state(lnk), .strap_cfg(scfg),
        .test_mode(tm), .power_down(pd), .spi_accept(spa),
        .dev_reset(dvr));
    hpsl_board hpsl_board_inst (.led_o(lo), .led_oe(loe), .pull(pull),
        .pin(pin), .xtal(xtal));
    // Clock
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    // Compare tasks
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: flag %b want %b", $time, got, exp);
        end
    endtask
    // One APB transfer, held until ready
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Pin reset with straps {hif,mode,spd,dup,an}
    task automatic hw_rst(input logic [6:0] s);
        @(posedge mclk);
        {hif, pull, rs, lm, an} <= s;
        hrb <= 1'b0;
        repeat (500) @(posedge mclk);
        chk32(32'(loe), 32'h0);
        chk1(dvr, 1'b1);
        hrb <= 1'b1;
        repeat (110) @(posedge mclk);
    endtask
    // Event pulse, then time for the interrupt path
    task automatic pulse(input logic [12:0] v);
        @(posedge mclk);
        ev <= v;
        @(posedge mclk);
        ev <= '0;
        repeat (4) @(posedge mclk);
    endtask
    function automatic logic [31:0] stat(input logic [6:0] s);
        return {21'h0, lnk.up, 1'b1, pdp, s[5:3] != 3'h7, s};
    endfunction
    task automatic finish_test;
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Watchdog
    initial begin
        #60000;
        n_errors++;
        finish_test();
    end
    // Main sequence
    initial begin
        {rst, hrb, ssb, an, lm, rs, hif, pull} = 10'h3FF;
        {psel, penable, pwrite, paddr, pwdata, pdp, ev, lnk} = '0;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        hw_rst(7'h7B);
        apb(1'b0, HPSL_OFS_STAT, 32'h0);
        chk32(rd, stat(7'h7B));
        chk32(32'(scfg), 32'h7B);
        chk1(tm, 1'b0);
        {an, lm, rs} <= 3'b010;
        apb(1'b0, HPSL_OFS_STAT, 32'h0);
        chk32(rd, stat(7'h7B));
        $display("straps done");
        apb(1'b1, HPSL_OFS_CMASK, 32'h1F);
        apb(1'b1, HPSL_OFS_SMASK, 32'hFF);
        for (int i = 0; i < 13; i++) begin
            fa = (i < 5) ? HPSL_OFS_CFLAG : HPSL_OFS_SFLAG;
            pulse(13'h1 << i);
            chk1(irq, 1'b0);
            apb(1'b0, fa, 32'h0);
            chk32(rd, 32'h1 << ((i < 5) ? i : i - 5));
            apb(1'b1, fa, rd);
            repeat (3) @(posedge mclk);
            chk1(irq, 1'b1);
        end
        apb(1'b1, HPSL_OFS_CMASK, 32'h0);
        pulse(13'h4);
        chk1(irq, 1'b1);
        apb(1'b1, HPSL_OFS_CMASK, 32'h4);
        repeat (3) @(posedge mclk);
        chk1(irq, 1'b0);
        apb(1'b0, 8'h20, 32'h0);
        chk32(rd, 32'h0);
        chk1(err, 1'b1);
        $display("interrupts done");
        lnk <= '{up: 1'b1, full_dup: 1'b1, spd100: 1'b0, activity: 1'b0};
        repeat (4) @(posedge mclk);
        chk32(32'(pin), 32'h2);
        apb(1'b0, HPSL_OFS_STAT, 32'h0);
        chk32(rd, stat(7'h7B));
        lnk <= '{up: 1'b1, full_dup: 1'b0, spd100: 1'b1, activity: 1'b1};
        {s0, s1, x0, x1} = 4'h0;
        repeat (200) begin
            @(posedge mclk);
            s0 = s0 | (pin[0] === 1'b0);
            s1 = s1 | (pin[0] === 1'b1);
            x0 = x0 | (xo === 1'b0);
            x1 = x1 | (xo === 1'b1);
        end
        chk32(32'(pin[2:1]), 32'h2);
        chk1(s0 & s1, 1'b1);
        chk1(x0 & x1, 1'b1);
        $display("LEDs done");
        ssb <= 1'b0;
        repeat (5) @(posedge mclk);
        chk1(spa, 1'b1);
        pdp <= 1'b1;
        repeat (5) @(posedge mclk);
        chk1(pd, 1'b1);
        chk1(spa, 1'b0);
        apb(1'b0, HPSL_OFS_STAT, 32'h0);
        chk32(rd, stat(7'h7B));
        {pdp, ssb} <= 2'b01;
        repeat (5) @(posedge mclk);
        chk1(pd, 1'b0);
        chk1(spa, 1'b0);
        $display("power and select done");
        hw_rst(7'h2C);
        chk1(irq, 1'b1);
        chk1(dvr, 1'b0);
        chk32(32'(scfg), 32'h2C);
        chk1(tm, 1'b1);
        apb(1'b0, HPSL_OFS_CFLAG, 32'h0);
        chk32(rd, 32'h0);
        apb(1'b0, HPSL_OFS_STAT, 32'h0);
        chk32(rd, stat(7'h2C));
        $display("pin reset done");
        finish_test();
    end
endmodule
`default_nettype wire
